/* hmr_consts.vh */
`ifndef HMR_CONSTS_VH
`define HMR_CONSTS_VH
// ****************************************
// Register offsets
// ****************************************
`define HMR_ADDR_MON_BYTE0 8'h0E
`define HMR_ADDR_MON_BYTE1 8'h0F
`define HMR_ADDR_MON_BYTE2 8'h10
`define HMR_ADDR_THERM 8'h11
`define HMR_ADDR_BATT 8'h12
`define HMR_ADDR_SRC_LVL 8'h13
// ****************************************
// Monitor modes
// ****************************************
`define HMR_MODE_PULSE 1'b0
`define HMR_MODE_POWER 1'b1
// ****************************************
// Field positions
// ****************************************
`define HMR_SHIFT_MSB 7
`define HMR_SHIFT_LSB 4
// ****************************************
// Reset values and timing
// ****************************************
`define HMR_RST_BYTE 8'h00
`define HMR_SAMPLE_PERIOD_NS 1000000
`define HMR_CLK_PERIOD_NS 5
`define HMR_SAMPLE_CYCLES (`HMR_SAMPLE_PERIOD_NS / `HMR_CLK_PERIOD_NS)
`endif

/* hmr_readout_regs.v */
`include "hmr_consts.vh"

// Summary of operation
// RULE1: Monitor byte layout follows the monitor mode from the control register.
// RULE2: Pulse mode: 24-bit count, low byte at lowest address.
// RULE3: Power mode: mantissa low bytes, top byte holds shift and mantissa 19:16.
// RULE4: Host rebuilds energy as mantissa shifted by exponent times scale factor.
// RULE5: Thermistor divider code exposed as an 8-bit reading.
// RULE6: Host may derive thermistor resistance from the code.
// RULE7: Battery voltage code held at its own address.
// RULE8: Source-level register reports regulation code set by strap pins.
// RULE9: Host should read the regulation setting register after writing it.
// RULE10: Storage readings refresh only at each monitoring interval.
// RULE11: Result-ready flag sets on new monitor result when enabled.
// RULE12: Straps rule while load bit is 0, written setting once it is 1.
// RULE13: Writes to result registers are ignored.
module hmr_readout_regs #(
    parameter SAMPLE_CYCLES = `HMR_SAMPLE_CYCLES
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire reg_rd_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // Configuration
    input wire energy_monitor_control_i,
    input wire load_config_i,
    input wire [7:0] source_regulation_setting_i,
    input wire monitor_irq_enable_i,
    input wire monitor_flag_clear_i,
    // Measurement sources, asynchronous
    input wire [5:0] source_level_strap_pins_i,
    input wire [7:0] thermistor_code_i,
    input wire [7:0] battery_code_i,
    // Monitor result from the energy measurement
    input wire mon_valid_i,
    input wire [23:0] mon_count_i,
    input wire [19:0] mon_mantissa_i,
    input wire [3:0] mon_shift_i,
    // Status
    output reg monitor_result_ready_o
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    wire [5:0] strap_sync;
    wire strap_settled;
    wire [7:0] therm_sync;
    wire therm_settled;
    wire [7:0] batt_sync;
    wire batt_settled;

    hmr_sync_word #(
        .WIDTH(6)
    ) strap_sync_inst (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(source_level_strap_pins_i),
        .word_o(strap_sync),
        .settled_o(strap_settled)
    );

    hmr_sync_word #(
        .WIDTH(8)
    ) therm_sync_inst (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(thermistor_code_i),
        .word_o(therm_sync),
        .settled_o(therm_settled)
    );

    hmr_sync_word #(
        .WIDTH(8)
    ) batt_sync_inst (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(battery_code_i),
        .word_o(batt_sync),
        .settled_o(batt_settled)
    );

    // ****************************************
    // Periodic sampling tick
    // ****************************************
    localparam [31:0] LAST_COUNT = SAMPLE_CYCLES - 1;
    reg [31:0] tick_cnt;
    wire tick = (tick_cnt == LAST_COUNT);

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt <= 32'h00000000;
        end else if (tick) begin
            tick_cnt <= 32'h00000000;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
        end
    end

    // ****************************************
    // Stored readings
    // ****************************************
    reg [7:0] energy_monitor_byte0;
    reg [7:0] energy_monitor_byte1;
    reg [7:0] energy_monitor_byte2;
    reg [7:0] thermistor_reading;
    reg [7:0] battery_voltage_reading;
    reg [7:0] source_level_reading;

    // ****************************************
    // Monitor byte layout per mode
    // ****************************************
    // Mode is taken at the edge that carries the result, so a later
    // mode change never reformats a stored result
    reg [7:0] next_mon_byte0;
    reg [7:0] next_mon_byte1;
    reg [7:0] next_mon_byte2;

    always @* begin
        next_mon_byte0 = energy_monitor_byte0;
        next_mon_byte1 = energy_monitor_byte1;
        next_mon_byte2 = energy_monitor_byte2;
        if (mon_valid_i) begin
            if (energy_monitor_control_i == `HMR_MODE_PULSE) begin // RULE1
                next_mon_byte0 = mon_count_i[7:0]; // RULE2
                next_mon_byte1 = mon_count_i[15:8]; // RULE2
                next_mon_byte2 = mon_count_i[23:16]; // RULE2
            end else begin
                next_mon_byte0 = mon_mantissa_i[7:0]; // RULE3
                next_mon_byte1 = mon_mantissa_i[15:8]; // RULE3
                next_mon_byte2 = {mon_shift_i, mon_mantissa_i[19:16]}; // RULE3
            end
        end
    end

    // Host writes never reach the stored results
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            energy_monitor_byte0 <= `HMR_RST_BYTE;
            energy_monitor_byte1 <= `HMR_RST_BYTE;
            energy_monitor_byte2 <= `HMR_RST_BYTE;
        end else begin
            energy_monitor_byte0 <= next_mon_byte0; // RULE13
            energy_monitor_byte1 <= next_mon_byte1; // RULE13
            energy_monitor_byte2 <= next_mon_byte2; // RULE13
        end
    end

    // ****************************************
    // Periodic converter readings
    // ****************************************
    // A word still moving at the tick is skipped until the next tick,
    // so a reading never mixes bits of two conversions
    wire therm_load = tick && therm_settled;
    wire batt_load = tick && batt_settled;
    reg [7:0] next_therm;
    reg [7:0] next_batt;
    reg [7:0] next_src;

    always @* begin
        next_therm = thermistor_reading;
        next_batt = battery_voltage_reading;
        next_src = source_level_reading;
        if (therm_load) begin
            next_therm = therm_sync; // RULE5
        end
        if (batt_load) begin
            next_batt = batt_sync; // RULE7 RULE10
        end
        if (tick) begin
            if (!load_config_i) begin
                if (strap_settled) begin
                    next_src = {2'b00, strap_sync}; // RULE8 RULE12
                end
            end else begin
                next_src = source_regulation_setting_i; // RULE12
            end
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thermistor_reading <= `HMR_RST_BYTE;
        end else begin
            thermistor_reading <= next_therm;
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            battery_voltage_reading <= `HMR_RST_BYTE;
        end else begin
            battery_voltage_reading <= next_batt;
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            source_level_reading <= `HMR_RST_BYTE;
        end else begin
            source_level_reading <= next_src; // RULE10
        end
    end

    // ****************************************
    // Result-ready flag, set wins over clear
    // ****************************************
    reg next_flag;

    always @* begin
        next_flag = monitor_result_ready_o;
        if (mon_valid_i && monitor_irq_enable_i) begin
            next_flag = 1'b1; // RULE11
        end else if (monitor_flag_clear_i) begin
            next_flag = 1'b0;
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            monitor_result_ready_o <= 1'b0;
        end else begin
            monitor_result_ready_o <= next_flag;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // Every register of this group is read-only: the write strobe and
    // write data reach no state at all
    reg [7:0] next_rdata;

    always @* begin
        case (reg_addr_i)
            `HMR_ADDR_MON_BYTE0: next_rdata = energy_monitor_byte0;
            `HMR_ADDR_MON_BYTE1: next_rdata = energy_monitor_byte1;
            `HMR_ADDR_MON_BYTE2: next_rdata = energy_monitor_byte2;
            `HMR_ADDR_THERM: next_rdata = thermistor_reading;
            `HMR_ADDR_BATT: next_rdata = battery_voltage_reading;
            `HMR_ADDR_SRC_LVL: next_rdata = source_level_reading;
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule

// ****************************************
// Word synchroniser with settle detect
// ****************************************
// Two flip-flops bring a level word into the clock domain; a third
// stage tells the reader when the word has held still for two cycles
module hmr_sync_word #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // Asynchronous word in
    input wire [WIDTH-1:0] async_i,
    // Synchronised word out
    output reg [WIDTH-1:0] word_o,
    output reg settled_o
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            word_o <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            word_o <= stage2;
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settled_o <= 1'b0;
        end else begin
            settled_o <= (stage2 == word_o);
        end
    end

endmodule

/* hmr_readout_properties.sv */
module hmr_readout_properties (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Watched ports
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic energy_monitor_control_i,
    input wire logic monitor_irq_enable_i,
    input wire logic monitor_flag_clear_i,
    input wire logic mon_valid_i,
    input wire logic [23:0] mon_count_i,
    input wire logic [19:0] mon_mantissa_i,
    input wire logic [3:0] mon_shift_i,
    input wire logic monitor_result_ready_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    pulse_byte_a: assert property ((mon_valid_i && !energy_monitor_control_i) ##1
        (reg_rd_i && reg_addr_i == 8'h0E) |=> reg_rdata_o == $past(mon_count_i[7:0], 2))
        else $error("pulse byte0 wrong");
    power_top_a: assert property ((mon_valid_i && energy_monitor_control_i) ##1
        (reg_rd_i && reg_addr_i == 8'h10) |=> reg_rdata_o ==
        {$past(mon_shift_i, 2), $past(mon_mantissa_i[19:16], 2)}) else $error("power top wrong");
    unmapped_read_a: assert property (reg_rd_i && (reg_addr_i < 8'h0E || reg_addr_i > 8'h13)
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    flag_set_a: assert property (mon_valid_i && monitor_irq_enable_i |=> monitor_result_ready_o)
        else $error("flag not set");
    flag_clear_a: assert property (monitor_result_ready_o && monitor_flag_clear_i &&
        !(mon_valid_i && monitor_irq_enable_i) |=> !monitor_result_ready_o) else $error("no clear");
    flag_hold_a: assert property (monitor_result_ready_o && !monitor_flag_clear_i
        |=> monitor_result_ready_o) else $error("flag dropped");
    flag_quiet_a: assert property (!monitor_result_ready_o && !(mon_valid_i && monitor_irq_enable_i)
        |=> !monitor_result_ready_o) else $error("flag rose");
endmodule
bind hmr_readout_regs hmr_readout_properties hmr_readout_properties_inst (.sys_clk_i, .rst_n_i,
    .reg_addr_i, .reg_rd_i, .reg_rdata_o, .energy_monitor_control_i, .monitor_irq_enable_i,
    .monitor_flag_clear_i, .mon_valid_i, .mon_count_i, .mon_mantissa_i, .mon_shift_i,
    .monitor_result_ready_o);

/* hmr_host_model.sv */
module hmr_host_model (
    // Register port
    input wire logic sys_clk_i,
    output logic [7:0] reg_addr_o = 8'h00,
    output logic reg_rd_o = 1'b0,
    output logic reg_wr_o = 1'b0,
    output logic [7:0] reg_wdata_o = 8'h00,
    input wire logic [7:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int R_DIV_OHMS = 22000;
    // Energy before scaling: mantissa shifted left by the exponent
    function automatic logic [35:0] rebuild_energy(input logic [7:0] b2, b1, b0);
        return {16'h0000, b2[3:0], b1, b0} << b2[7:4];
    endfunction
    // Thermistor resistance from the divider code
    function automatic int therm_ohms(input logic [7:0] code);
        return R_DIV_OHMS * int'(code) / (256 - int'(code));
    endfunction
    // One-cycle strobe; data is taken half a cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i) {reg_addr_o, reg_rd_o} = {a, 1'b1};
        @(negedge sys_clk_i) reg_rd_o = 1'b0;
        d = reg_rdata_i;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk_i) {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, v, 1'b1};
        @(negedge sys_clk_i) reg_wr_o = 1'b0;
    endtask
endmodule

/* hmr_tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, reg_rd_i, reg_wr_i, monitor_result_ready_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d, b1, b2;
    logic energy_monitor_control_i = 1'b0, load_config_i = 1'b0, monitor_irq_enable_i = 1'b1;
    logic monitor_flag_clear_i = 1'b0, mon_valid_i = 1'b0;
    logic [7:0] source_regulation_setting_i = 8'h77, thermistor_code_i = 8'h5A;
    logic [7:0] battery_code_i = 8'hC4;
    logic [5:0] source_level_strap_pins_i = 6'h2B;
    logic [23:0] mon_count_i = 24'hA5C3E1;
    logic [19:0] mon_mantissa_i = 20'h9ABCD;
    logic [3:0] mon_shift_i = 4'h7;
    int failures = 0;
    int n_compared = 0;
    hmr_readout_regs #(.SAMPLE_CYCLES(8)) hmr_readout_regs_inst (.*);
    hmr_host_model hmr_host_model_inst (.sys_clk_i, .reg_addr_o(reg_addr_i), .reg_rd_o(reg_rd_i),
        .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        hmr_host_model_inst.rd(a, d);
        check(d, e);
    endtask
    task automatic finish_test;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_adc;
        repeat (20) @(negedge sys_clk_i);
        rc(8'h11, 8'h5A);
        rc(8'h12, 8'hC4);
        rc(8'h13, 8'h2B);
        check(hmr_host_model_inst.therm_ohms(8'h5A), 36'd11927);
        battery_code_i = 8'h3C;
        rc(8'h12, 8'hC4);
        load_config_i = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        rc(8'h12, 8'h3C);
        rc(8'h13, 8'h77);
        $display("converter test done");
    endtask
    task automatic t_pulse;
        @(negedge sys_clk_i) mon_valid_i = 1'b1;
        rc(8'h0E, 8'hE1);
        mon_valid_i = 1'b0;
        rc(8'h0F, 8'hC3);
        rc(8'h10, 8'hA5);
        check(monitor_result_ready_o, 8'h01);
        $display("pulse test done");
    endtask
    task automatic t_power;
        @(negedge sys_clk_i) {monitor_flag_clear_i, monitor_irq_enable_i} = 2'b10;
        @(negedge sys_clk_i) {monitor_flag_clear_i, energy_monitor_control_i, mon_valid_i} = 3'b011;
        rc(8'h10, 8'h79);
        mon_valid_i = 1'b0;
        rc(8'h0E, 8'hCD);
        rc(8'h0F, 8'hAB);
        check(monitor_result_ready_o, 8'h00);
        hmr_host_model_inst.rd(8'h10, b2);
        hmr_host_model_inst.rd(8'h0F, b1);
        hmr_host_model_inst.rd(8'h0E, d);
        check(hmr_host_model_inst.rebuild_energy(b2, b1, d), 36'h004D5E680);
        hmr_host_model_inst.wr(8'h0E, 8'hFF);
        rc(8'h0E, 8'hCD);
        rc(8'h20, 8'h00);
        $display("power test done");
    endtask
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    initial begin
        repeat (16) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        t_adc;
        t_pulse;
        t_power;
        finish_test;
    end
endmodule
